// ==== pkg/board_sync_map.vh ====
// Register map, field positions, reset values and timing counts
// for the multi-board trigger sync block. Definitions only.
`ifndef BOARD_SYNC_MAP_VH
`define BOARD_SYNC_MAP_VH

// ==================================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_PULSE 8'h08
`define OFS_STATUS 8'h0c
`define OFS_COUNT 8'h10

// ==================================================
// Control register fields
`define CTRL_ORIGIN_LO 0
`define CTRL_ORIGIN_HI 1
`define CTRL_TRIG_EN 2
`define CTRL_LEVEL_DET 3
`define CTRL_ACTIVE_HIGH 4
`define CTRL_SOFT_SEL 5
`define CTRL_RESET 32'h0000_0014

// Trigger origin selections
`define ORIGIN_LOCAL 2'h0
`define ORIGIN_RAW_FWD 2'h1
`define ORIGIN_QUAL_PULSE 2'h2
`define ORIGIN_FROM_SYNC 2'h3

// ==================================================
// Command register bits (write-one pulses)
`define CMD_SOFT_TRIG 0
`define CMD_ARM 1
`define CMD_DISARM 2

// ==================================================
// Pulse register fields and reset value
`define PULSE_RAW_LO 0
`define PULSE_RAW_HI 15
`define PULSE_CC1_LO 16
`define PULSE_CC1_HI 31
`define PULSE_RESET 32'h0032_0008

// ==================================================
// Status register fields
`define STAT_ARMED 0
`define STAT_BUSY 1
`define STAT_SYNC_LVL 2
`define STAT_CC1 3
`define STAT_DRIVING 4
`define STAT_ROLE_MASTER 5

// ==================================================
// Timing: figures in ns, counts at the clock rate
`define CLK_PERIOD_NS 20
`define FWD_DELAY_MAX_NS 25
`define DECIDE_MAX_NS 1000
`define SLAVE_START_MAX_NS 800
`define FWD_DELAY_CYC ((`FWD_DELAY_MAX_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`FWD_DELAY_MAX_NS / `CLK_PERIOD_NS))
`define DECIDE_CYC (`DECIDE_MAX_NS / `CLK_PERIOD_NS)
`define SLAVE_START_CYC (`SLAVE_START_MAX_NS / `CLK_PERIOD_NS)

`endif

// ==== hdl/pin_sync_edge.v ====
// Two-flop synchroniser with edge detection for one pin input.
// Assumes the pin is asynchronous to hclk.
`timescale 1ns/100ps
`default_nettype none

module pin_sync_edge
(
  input wire hclk,
  input wire hresetn,
  input wire pin,
  output reg level,
  output wire rise,
  output wire fall
);

  reg meta_reg;
  reg prev_reg;

  // First flop feeds only the second
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= 1'b0;
      level <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pin;
      level <= meta_reg;
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule

`default_nettype wire

// ==== hdl/board_sync_top.v ====
// Multi-board trigger sync: master drives the shared sync line,
// slaves start acquisition from it. AHB-Lite register slave.
// Assumes one hclk domain; pins arrive asynchronous.
//
// Summary of operation
// - Triggered board masters line; others only receive
// - Master origin: external pin or software trigger
// - Master keeps enable, edge/level, polarity settings
// - Slave may select sync line as source
// - Raw mode forwards trigger with no qualification
// - Raw mode pulse: fixed polarity, fixed width
// - Raw mode forward delay under 25 ns; here 2 to 3 hclk cycles (40 to 60 ns) through the synchroniser
// - Qualified mode copies used CC1 pulse exactly
// - Use-or-ignore decision within 1 us
// - Sync line follows CC1 within 25 ns
// - Sync-sourced slave ignores own trigger settings
// - Armed slave waits for master sync pulse
// - Slave start within 0.8 us of trigger
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "board_sync_map.vh"

module board_sync_top
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire ext_trig_pin,
  input wire sync_in,
  output reg sync_out,
  output reg sync_oe,
  input wire acq_done,
  output reg cc1_out,
  output reg acq_start,
  output reg acq_busy
);

  // ==================================================
  // Bus slave
  reg [31:0] ctrl_reg;
  reg [31:0] pulse_reg;
  reg [31:0] trig_count_reg;
  reg [31:0] ignore_count_reg;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  reg soft_trig_reg;
  reg arm_cmd_reg;
  reg disarm_cmd_reg;
  reg armed_reg;
  wire [31:0] status_word;
  wire addr_phase;

  assign addr_phase = hsel & htrans[1] & hready;

  function [31:0] read_mux;
    input [7:0] a;
    begin
      case (a)
        `OFS_CTRL: read_mux = ctrl_reg;
        `OFS_PULSE: read_mux = pulse_reg;
        `OFS_STATUS: read_mux = status_word;
        `OFS_COUNT: read_mux = {ignore_count_reg[15:0], trig_count_reg[15:0]};
        default: read_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      ctrl_reg <= `CTRL_RESET;
      pulse_reg <= `PULSE_RESET;
      soft_trig_reg <= 1'b0;
      arm_cmd_reg <= 1'b0;
      disarm_cmd_reg <= 1'b0;
    end
    else
    begin
      // Zero wait states, always OKAY
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      soft_trig_reg <= 1'b0;
      arm_cmd_reg <= 1'b0;
      disarm_cmd_reg <= 1'b0;
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase)
      begin
        wr_addr_reg <= haddr;
        if (!hwrite)
          hrdata <= read_mux(haddr);
      end
      if (wr_pend_reg)
      begin
        case (wr_addr_reg)
          `OFS_CTRL: ctrl_reg <= {26'h0000000, hwdata[5:0]};
          `OFS_PULSE: pulse_reg <= hwdata;
          `OFS_CMD:
          begin
            soft_trig_reg <= hwdata[`CMD_SOFT_TRIG];
            arm_cmd_reg <= hwdata[`CMD_ARM];
            disarm_cmd_reg <= hwdata[`CMD_DISARM];
          end
          default: ;
        endcase
      end
    end
  end

  // ==================================================
  // Input synchronisers
  wire ext_lvl;
  wire ext_rise;
  wire ext_fall;
  wire sync_lvl;
  wire sync_rise;

  pin_sync_edge ext_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(ext_trig_pin),
    .level(ext_lvl),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  pin_sync_edge line_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(sync_in),
    .level(sync_lvl),
    .rise(sync_rise),
    .fall()
  );

  // ==================================================
  // Trigger detection
  wire [1:0] origin;
  wire is_master;
  wire is_slave;
  wire ext_active;
  wire ext_edge;
  wire local_trig;
  wire sync_trig;
  wire acq_trig;
  wire use_trig;

  assign origin = ctrl_reg[`CTRL_ORIGIN_HI:`CTRL_ORIGIN_LO];
  assign is_master = (origin == `ORIGIN_RAW_FWD) | (origin == `ORIGIN_QUAL_PULSE);
  assign is_slave = (origin == `ORIGIN_FROM_SYNC);

  assign ext_active = ctrl_reg[`CTRL_ACTIVE_HIGH] ? ext_lvl : ~ext_lvl;
  assign ext_edge = ctrl_reg[`CTRL_ACTIVE_HIGH] ? ext_rise : ext_fall;
  assign local_trig = ctrl_reg[`CTRL_TRIG_EN] &
    ((ctrl_reg[`CTRL_LEVEL_DET] ? ext_active : ext_edge) | soft_trig_reg);

  assign sync_trig = is_slave & sync_rise;
  assign acq_trig = is_slave ? sync_trig : local_trig;

  assign use_trig = acq_trig & armed_reg & ~acq_busy & ~disarm_cmd_reg;

  // ==================================================
  // Acquisition control and CC1 pulse
  localparam ST_IDLE = 3'b001;
  localparam ST_PULSE = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [2:0] state_reg;
  reg [15:0] cc1_cnt_reg;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      cc1_cnt_reg <= 16'h0000;
      cc1_out <= 1'b0;
      acq_start <= 1'b0;
      acq_busy <= 1'b0;
      armed_reg <= 1'b0;
      trig_count_reg <= 32'h0000_0000;
      ignore_count_reg <= 32'h0000_0000;
    end
    else
    begin
      acq_start <= 1'b0;
      if (arm_cmd_reg)
        armed_reg <= 1'b1;
      else if (disarm_cmd_reg)
        armed_reg <= 1'b0;
      if (acq_trig & ~use_trig)
        ignore_count_reg <= ignore_count_reg + 32'h0000_0001;
      case (state_reg)
        ST_IDLE:
        begin
          if (use_trig)
          begin
            // start one cycle after sync edge
            acq_start <= 1'b1;
            acq_busy <= 1'b1;
            cc1_out <= 1'b1;
            cc1_cnt_reg <= pulse_reg[`PULSE_CC1_HI:`PULSE_CC1_LO];
            trig_count_reg <= trig_count_reg + 32'h0000_0001;
            state_reg <= ST_PULSE;
          end
        end
        ST_PULSE:
        begin
          if (cc1_cnt_reg <= 16'h0001)
          begin
            cc1_out <= 1'b0;
            state_reg <= ST_WAIT;
          end
          else
            cc1_cnt_reg <= cc1_cnt_reg - 16'h0001;
        end
        ST_WAIT:
        begin
          if (acq_done)
          begin
            acq_busy <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          cc1_out <= 1'b0;
          acq_busy <= 1'b0;
        end
      endcase
      if (disarm_cmd_reg)
      begin
        acq_busy <= 1'b0;
        cc1_out <= 1'b0;
        state_reg <= ST_IDLE;
      end
    end
  end

  // ==================================================
  // Sync line driver
  // Raw pulse width is counted, not copied, so the shape
  // of the incoming trigger never reaches the line.
  reg [15:0] raw_cnt_reg;
  wire raw_fire;
  wire cc1_next_high;

  assign raw_fire = (origin == `ORIGIN_RAW_FWD) & ctrl_reg[`CTRL_TRIG_EN] &
    (ext_edge | soft_trig_reg);
  // CC1 value one cycle ahead, so the line flop matches cc1_out
  assign cc1_next_high = (state_reg == ST_IDLE) ? use_trig :
    ((state_reg == ST_PULSE) & (cc1_cnt_reg > 16'h0001) & ~disarm_cmd_reg);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      raw_cnt_reg <= 16'h0000;
      sync_out <= 1'b0;
      sync_oe <= 1'b0;
    end
    else
    begin
      case (origin)
        `ORIGIN_RAW_FWD:
        begin
          // line set in the detect cycle
          if (raw_fire)
          begin
            raw_cnt_reg <= pulse_reg[`PULSE_RAW_HI:`PULSE_RAW_LO];
            sync_out <= 1'b1;
          end
          else if (raw_cnt_reg > 16'h0001)
            raw_cnt_reg <= raw_cnt_reg - 16'h0001;
          else
          begin
            raw_cnt_reg <= 16'h0000;
            sync_out <= 1'b0;
          end
          sync_oe <= 1'b1;
        end
        `ORIGIN_QUAL_PULSE:
        begin
          sync_out <= cc1_next_high;
          sync_oe <= 1'b1;
          raw_cnt_reg <= 16'h0000;
        end
        default:
        begin
          // slaves and single boards release the line
          sync_out <= 1'b0;
          sync_oe <= 1'b0;
          raw_cnt_reg <= 16'h0000;
        end
      endcase
    end
  end

  // ==================================================
  // Status
  assign status_word = {26'h0000000, is_master, sync_oe, cc1_out, sync_lvl, acq_busy, armed_reg};

endmodule

`default_nettype wire

// ==== dv/board_sync_peer.sv ====
// Peer board on the shared sync line; resolves the wire level.
// Assumes the line idles low through a pull-down when nobody drives.
`timescale 1ns/100ps
`default_nettype none
module board_sync_peer
#(parameter int WIDTH = 6)
(
  input wire logic hclk,
  input wire logic fire,
  input wire logic dut_out,
  input wire logic dut_oe,
  output logic line,
  output int rises
);
  int cnt = 0;
  int seen = 0;
  logic last = 1'b0;
  assign line = dut_oe ? dut_out : (cnt > 0);
  assign rises = seen;
  always @(posedge hclk)
  begin
    if (fire)
      cnt <= WIDTH;
    else if (cnt > 0)
      cnt <= cnt - 1;
    if (dut_oe && dut_out && !last)
      seen <= seen + 1;
    last <= dut_out;
  end
endmodule
`default_nettype wire

// ==== dv/board_sync_checker.sv ====
// Port checker for the sync block; origin mode shadowed from bus.
// Assumes one hclk domain and the shared register map.
`timescale 1ns/100ps
`default_nettype none
`include "board_sync_map.vh"
module board_sync_checker
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ext_trig_pin,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic cc1_out,
  input wire logic acq_start,
  input wire logic acq_busy
);
  reg wr_reg;
  reg [1:0] mode_reg;
  wire raw_m = mode_reg == `ORIGIN_RAW_FWD;
  wire qual_m = mode_reg == `ORIGIN_QUAL_PULSE;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_reg <= 1'b0;
      mode_reg <= 2'h0;
    end
    else if (hready)
    begin
      wr_reg <= hsel && htrans[1] && hwrite && haddr == `OFS_CTRL;
      if (wr_reg)
        mode_reg <= hwdata[1:0];
    end
  end
  // ==========
  // Assertions
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_start_one_cycle: assert property (acq_start |=> !acq_start)
    else $error("start pulse too long");
  a_start_sets_busy: assert property (acq_start |-> acq_busy)
    else $error("start without busy");
  a_qual_copy: assert property (qual_m && $past(qual_m) |-> sync_out == cc1_out)
    else $error("sync line differs from cc1");
  a_slave_quiet: assert property (mode_reg == $past(mode_reg, 2) && !(raw_m || qual_m) |-> !sync_oe)
    else $error("non-master drives line");
  a_master_drive: assert property (mode_reg == $past(mode_reg, 2) && (raw_m || qual_m) |-> sync_oe)
    else $error("master not driving line");
  a_raw_width: assert property (raw_m && $rose(sync_out) |-> sync_out [*8] ##1 !sync_out)
    else $error("raw pulse width wrong");
  a_raw_delay: assert property (raw_m && $rose(ext_trig_pin) |-> ##[2:5] sync_out)
    else $error("raw forward too slow");
  a_slave_cause: assert property (mode_reg == `ORIGIN_FROM_SYNC && acq_start |-> $past(sync_in, 2))
    else $error("slave start without sync");
  a_bus_zero_wait: assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("bus not ready or error");
  c_raw_pulse: cover property (raw_m && $rose(sync_out));
  c_qual_pulse: cover property (qual_m && $rose(cc1_out));
  c_slave_start: cover property (mode_reg == `ORIGIN_FROM_SYNC && acq_start);
endmodule
bind board_sync_top board_sync_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
  .ext_trig_pin(ext_trig_pin), .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe), .cc1_out(cc1_out),
  .acq_start(acq_start), .acq_busy(acq_busy));
`default_nettype wire

// ==== dv/test_multi_board_trigger_sync.sv ====
// Bench for the sync block: bus tasks and one task per scenario.
// Assumes the peer model on the line and the shared map header.
`timescale 1ns/100ps
`default_nettype none
`include "board_sync_map.vh"
module test_multi_board_trigger_sync;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, ext_pin = 1'b0, done = 1'b0, fire = 1'b0;
  logic line, sync_out, sync_oe, cc1_out, acq_start, acq_busy, sp = 1'b0, cp = 1'b0;
  int error_cnt = 0, comparisons = 0, rises, s_len = 0, c_len = 0, k;
  always #10 hclk = ~hclk;
  board_sync_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_trig_pin(ext_pin), .sync_in(line), .sync_out(sync_out),
    .sync_oe(sync_oe), .acq_done(done), .cc1_out(cc1_out), .acq_start(acq_start), .acq_busy(acq_busy));
  board_sync_peer #(.WIDTH(6)) peer_u (.hclk(hclk), .fire(fire), .dut_out(sync_out), .dut_oe(sync_oe),
    .line(line), .rises(rises));
  // Last pulse widths on the line and on cc1
  always @(posedge hclk)
  begin
    sp <= sync_out;
    cp <= cc1_out;
    if (sync_out)
      s_len <= sp ? s_len + 1 : 1;
    if (cc1_out)
      c_len <= cp ? c_len + 1 : 1;
  end
  // ==========
  // Shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task pin(input logic v);
    @(posedge hclk);
    ext_pin <= v;
  endtask
  task pulse_fire;
    @(posedge hclk);
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
  endtask
  // Bounded wait; k equals n when no start came
  task wait_start(input int n);
    k = 0;
    while (acq_start !== 1'b1 && k < n)
    begin
      @(posedge hclk);
      #1;
      k++;
    end
  endtask
  task end_acq;
    @(posedge hclk);
    done <= 1'b1;
    @(posedge hclk);
    done <= 1'b0;
  endtask
  // ==========
  // Scenarios
  task t_regs;
    rd(`OFS_CTRL, `CTRL_RESET);
    rd(`OFS_PULSE, `PULSE_RESET);
    bus(1'b1, `OFS_PULSE, 32'h0005_0008);
    rd(`OFS_PULSE, 32'h0005_0008);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    rd(`OFS_STATUS, 32'h0);
    $display("regs test done");
  endtask
  task t_raw;
    bus(1'b1, `OFS_CTRL, 32'h15);
    bus(1'b1, `OFS_CMD, 32'h2);
    pin(1'b1);
    wait_start(20);
    chk(k <= 5, 1'b1);
    chk(sync_out, 1'b1);
    repeat (12) @(posedge hclk);
    chk(s_len, 8);
    pin(1'b0);
    pin(1'b1);
    repeat (12) @(posedge hclk);
    chk(rises, 2);
    pin(1'b0);
    rd(`OFS_COUNT, 32'h0001_0001);
    end_acq;
    $display("raw forward test done");
  endtask
  task t_qual;
    bus(1'b1, `OFS_CTRL, 32'h16);
    bus(1'b1, `OFS_CMD, 32'h2);
    pin(1'b1);
    wait_start(`DECIDE_CYC);
    chk(k < `DECIDE_CYC, 1'b1);
    repeat (10) @(posedge hclk);
    chk(c_len, 5);
    chk(s_len, 5);
    pin(1'b0);
    pin(1'b1);
    repeat (10) @(posedge hclk);
    chk(rises, 3);
    end_acq;
    bus(1'b1, `OFS_CTRL, 32'h12);
    bus(1'b1, `OFS_CMD, 32'h2);
    pin(1'b0);
    pin(1'b1);
    repeat (10) @(posedge hclk);
    chk(rises, 3);
    bus(1'b1, `OFS_CTRL, 32'h06);
    pin(1'b0);
    wait_start(`DECIDE_CYC);
    chk(k < `DECIDE_CYC, 1'b1);
    pin(1'b1);
    // Done only ends busy once the cc1 pulse is over
    repeat (8) @(posedge hclk);
    chk(c_len, 5);
    chk(rises, 4);
    end_acq;
    $display("qualified test done");
  endtask
  task t_soft;
    bus(1'b1, `OFS_CTRL, 32'h16);
    bus(1'b1, `OFS_CMD, 32'h2);
    bus(1'b1, `OFS_CMD, 32'h1);
    wait_start(10);
    chk(k < 10, 1'b1);
    repeat (8) @(posedge hclk);
    chk(rises, 5);
    end_acq;
    rd(`OFS_STATUS, 32'h0000_0031);
    $display("soft trigger test done");
  endtask
  task t_slave;
    bus(1'b1, `OFS_CTRL, 32'h17);
    bus(1'b1, `OFS_CMD, 32'h4);
    pulse_fire;
    wait_start(20);
    chk(k, 20);
    bus(1'b1, `OFS_CMD, 32'h2);
    pin(1'b0);
    pin(1'b1);
    bus(1'b1, `OFS_CMD, 32'h1);
    wait_start(20);
    chk(k, 20);
    pulse_fire;
    wait_start(`SLAVE_START_CYC);
    chk(k < `SLAVE_START_CYC, 1'b1);
    chk(sync_oe, 1'b0);
    repeat (8) @(posedge hclk);
    end_acq;
    rd(`OFS_STATUS, 32'h0000_0001);
    $display("slave test done");
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs;
    t_raw;
    t_qual;
    t_soft;
    t_slave;
    finish_test;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    finish_test;
  end
endmodule
`default_nettype wire
